// ==== hdl/rcs_defs.vh ====
// constants for the reset cause and status block
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH
`define RCS_AW          5
`define RCS_A_RST_CTRL  5'h00
`define RCS_A_STACK     5'h04
`define RCS_A_TOS       5'h08
`define RCS_A_IRQ_REQ   5'h0c
`define RCS_A_EVT_ST    5'h10
`define RCS_A_EVT_MSK   5'h14
`define RCS_A_CFG       5'h18
`define RCS_RESP_OKAY   2'h0
`define RCS_RESP_SLVERR 2'h2
`define RCS_B_SWBO_EN   6
`define RCS_B_RINS      4
`define RCS_B_TO        3
`define RCS_B_PDN       2
`define RCS_B_POR       1
`define RCS_B_BRO       0
`define RCS_B_SFULL     7
`define RCS_B_SUNDER    6
`define RCS_B_SERR_EN   0
`define RCS_RCTL_POR    7'h5c
`define RCS_RCTL_MASK   7'h5f
`define RCS_PC_W        21
`define RCS_PC_ZERO     21'h000000
`define RCS_PC_STEP     21'h000002
`define RCS_VEC_HI      21'h000008
`define RCS_VEC_LO      21'h000018
`define RCS_SP_W        5
`define RCS_SP_ZERO     5'h00
`define RCS_SP_ONE      5'h01
`define RCS_PM_FULL     2'h0
`define RCS_PM_RUN      2'h1
`define RCS_PM_IDLE     2'h2
`define RCS_PM_SLEEP    2'h3
`define RCS_BM_OFF      2'h0
`define RCS_BM_SW       2'h1
`define RCS_BM_NOSLP    2'h2
`define RCS_BM_ON       2'h3
`define RCS_EV_N        8
`define RCS_EV_BRO       0
`define RCS_EV_MRST      1
`define RCS_EV_WDOG_RST  2
`define RCS_EV_WDOG_WAKE 3
`define RCS_EV_RINS      4
`define RCS_EV_SFULL     5
`define RCS_EV_SUNDER    6
`define RCS_EV_IRQ_WAKE 7
`endif

// ==== hdl/rcs_reset_cause.v ====
// reset cause flags, restart address and wake-up stack push
`timescale 1ns/1ps
`include "rcs_defs.vh"

// Functional notes
// - registers without reset value keep their contents on every warm reset.
// - reset-valued registers take values per power-on, warm reset or wake-up.
// - watchdog wake-up resumes normal run; most registers stay untouched.
// - power-on: pc zero, set instr/timeout/power-down, clear cause and stack.
// - reset instr clears its flag; brown-out sets three, clears its own.
// - master clear in power-managed run sets timeout only.
// - master clear in idle or sleep sets timeout, clears power-down.
// - master clear in full power restarts at zero, flags untouched.
// - watchdog in full power or run: restart zero, clear timeout.
// - watchdog in idle or sleep: resume at pc plus two, clear two flags.
// - interrupt wake clears power-down; pc plus two or vector if enabled.
// - overflow with stack error reset enabled restarts zero, sets full flag.
// - underflow always sets its flag; resets only when enable is one.
// - soft brown-out enable: one at power-on, else kept or zeroed.
// - interrupt wake with global enable pushes pc and bumps stack pointer.
// - interrupt wake leaves a request bit set naming the wake source.
// - soft brown-out enable works only in mode 01, else reads zero.
module rcs_reset_cause (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        master_clear_pin_n,
  input  wire        brownout_pin,
  input  wire        watchdog_timer_timeout,
  input  wire        reset_instr_exec,
  input  wire        stack_overflow,
  input  wire        stack_underflow,
  input  wire        irq_wake,
  input  wire [2:0]  irq_wake_src,
  input  wire        irq_wake_high_prio,
  input  wire        high_prio_global_irq_enable,
  input  wire        low_prio_global_irq_enable,
  input  wire [1:0]  pm_mode,
  input  wire [1:0]  brownout_mode_cfg,
  input  wire [20:0] pc_in,
  output wire        core_reset,
  output wire        pc_load,
  output wire [20:0] pc_load_val,
  output wire        brownout_detect_en,
  output wire [7:0]  irq_request_regs,
  output wire        irq,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready
);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = dat[i*8 +: 8];
        end
      end
    end
  endfunction

  reg                   mrst_s1_ff, mrst_s2_ff, mrst_d_ff;
  reg                   bro_s1_ff, bro_s2_ff, bro_d_ff;
  reg  [6:0]            rctl_ff, nxt_rctl;
  reg                   sfull_ff, nxt_sfull;
  reg                   sunder_ff, nxt_sunder;
  reg  [`RCS_SP_W-1:0]  sp_ff, nxt_sp;
  reg  [`RCS_PC_W-1:0]  tos_ff, nxt_tos;
  reg  [`RCS_PC_W-1:0]  pcv_ff, nxt_pcv;
  reg                   pcld_ff, crst_ff;
  reg  [7:0]            ireq_ff;
  reg  [`RCS_EV_N-1:0]  evt_st_ff, evt_msk_ff;
  reg                   serr_en_ff;
  reg                   aw_full_ff, w_full_ff, bvalid_ff;
  reg  [`RCS_AW-1:0]    aw_addr_ff;
  reg  [31:0]           w_data_ff;
  reg  [3:0]            w_strb_ff;
  reg  [1:0]            bresp_ff, rresp_ff;
  reg                   rvalid_ff;
  reg  [31:0]           rdata_ff, rd_mux;
  reg                   rd_hit;

  // only the second synchroniser stage and its delayed copy are compared
  wire mrst_fall = mrst_d_ff & ~mrst_s2_ff;
  wire bro_rise  = bro_s2_ff & ~bro_d_ff;
  wire asleep    = (pm_mode == `RCS_PM_IDLE) || (pm_mode == `RCS_PM_SLEEP);
  wire sw_mode   = (brownout_mode_cfg == `RCS_BM_SW);
  wire swbo_en_q = rctl_ff[`RCS_B_SWBO_EN];

  assign brownout_detect_en =
    (brownout_mode_cfg == `RCS_BM_ON) ||
    ((brownout_mode_cfg == `RCS_BM_NOSLP) && (pm_mode != `RCS_PM_SLEEP)) ||
    (sw_mode && swbo_en_q);

  // one event handled per cycle, brown-out first; a later one is dropped
  wire ev_bro  = bro_rise & brownout_detect_en;
  wire h1      = ev_bro;
  wire ev_mrst = mrst_fall & ~h1;
  wire h2      = h1 | mrst_fall;
  wire ev_wdog = watchdog_timer_timeout & ~h2;
  wire wdog_wk = ev_wdog & asleep;
  wire wdog_rs = ev_wdog & ~asleep;
  wire h3      = h2 | watchdog_timer_timeout;
  wire ev_rins = reset_instr_exec & ~h3;
  wire h4      = h3 | reset_instr_exec;
  wire ev_sful = stack_overflow & serr_en_ff & ~h4;
  wire h5      = h4 | ev_sful;
  wire ev_sunf = stack_underflow & ~h5;
  wire h6      = h5 | ev_sunf;
  wire ev_irq  = irq_wake & (pm_mode != `RCS_PM_FULL) & ~h6;
  wire gie_any = high_prio_global_irq_enable | low_prio_global_irq_enable;
  wire warm_rst = ev_bro | ev_mrst | wdog_rs | ev_rins | ev_sful |
                  (ev_sunf & serr_en_ff);

  wire [`RCS_EV_N-1:0] ev_vec = {ev_irq, ev_sunf, ev_sful, ev_rins,
                                 wdog_wk, wdog_rs, ev_mrst, ev_bro};

  wire do_wr = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire wr_rc = do_wr && (aw_addr_ff == `RCS_A_RST_CTRL);
  wire wr_sk = do_wr && (aw_addr_ff == `RCS_A_STACK);
  wire wr_ts = do_wr && (aw_addr_ff == `RCS_A_TOS);
  wire wr_iq = do_wr && (aw_addr_ff == `RCS_A_IRQ_REQ);
  wire wr_es = do_wr && (aw_addr_ff == `RCS_A_EVT_ST);
  wire wr_em = do_wr && (aw_addr_ff == `RCS_A_EVT_MSK);
  wire wr_cf = do_wr && (aw_addr_ff == `RCS_A_CFG);
  wire wr_hit = wr_rc | wr_sk | wr_ts | wr_iq | wr_es | wr_em | wr_cf;
  wire [31:0] wm_rc = merge({25'h0, rctl_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wm_sk = merge({24'h000000, sfull_ff, sunder_ff, 1'b0,
                             sp_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wm_ts = merge({11'h000, tos_ff}, w_data_ff, w_strb_ff);

  always @* begin
    nxt_rctl   = rctl_ff;
    nxt_sfull  = sfull_ff;
    nxt_sunder = sunder_ff;
    nxt_sp     = sp_ff;
    nxt_tos    = tos_ff;
    nxt_pcv    = pcv_ff;
    // software writes, hardware events below override them
    if (wr_rc) begin
      nxt_rctl = wm_rc[6:0] & `RCS_RCTL_MASK;
    end
    if (wr_sk) begin
      nxt_sfull  = wm_sk[`RCS_B_SFULL];
      nxt_sunder = wm_sk[`RCS_B_SUNDER];
      nxt_sp     = wm_sk[`RCS_SP_W-1:0];
    end
    if (wr_ts) begin
      nxt_tos = wm_ts[`RCS_PC_W-1:0];
    end
    // warm-reset category values for stack registers and restart address
    if (warm_rst) begin
      nxt_tos = `RCS_PC_ZERO;
      nxt_sp  = `RCS_SP_ZERO;
      nxt_pcv = `RCS_PC_ZERO;
      // kept only when soft mode and set
      nxt_rctl[`RCS_B_SWBO_EN] = sw_mode & swbo_en_q;
    end
    if (ev_bro) begin
      nxt_rctl[`RCS_B_RINS] = 1'b1;
      nxt_rctl[`RCS_B_TO]   = 1'b1;
      nxt_rctl[`RCS_B_PDN]  = 1'b1;
      nxt_rctl[`RCS_B_BRO]  = 1'b0;
    end
    if (ev_mrst) begin
      case (pm_mode)
        `RCS_PM_RUN: begin
          nxt_rctl[`RCS_B_TO] = 1'b1;
        end
        // idle and sleep also clear power-down
        `RCS_PM_IDLE, `RCS_PM_SLEEP: begin
          nxt_rctl[`RCS_B_TO]  = 1'b1;
          nxt_rctl[`RCS_B_PDN] = 1'b0;
        end
        // full power leaves every flag as it stands
        default: begin
        end
      endcase
    end
    if (wdog_rs) begin
      nxt_rctl[`RCS_B_TO] = 1'b0;
    end
    // watchdog wake resumes after current pc
    if (wdog_wk) begin
      nxt_rctl[`RCS_B_TO]  = 1'b0;
      nxt_rctl[`RCS_B_PDN] = 1'b0;
      nxt_pcv = pc_in + `RCS_PC_STEP;
    end
    if (ev_rins) begin
      nxt_rctl[`RCS_B_RINS] = 1'b0;
    end
    if (ev_sful) begin
      nxt_sfull = 1'b1;
    end
    if (ev_sunf) begin
      nxt_sunder = 1'b1;
    end
    if (ev_irq) begin
      nxt_rctl[`RCS_B_PDN] = 1'b0;
      if (gie_any) begin
        nxt_pcv = irq_wake_high_prio ? `RCS_VEC_HI : `RCS_VEC_LO;
        nxt_tos = pc_in;
        nxt_sp  = sp_ff + `RCS_SP_ONE;
      end else begin
        nxt_pcv = pc_in + `RCS_PC_STEP;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rctl_ff   <= `RCS_RCTL_POR;
      sfull_ff  <= 1'b0;
      sunder_ff <= 1'b0;
      sp_ff     <= `RCS_SP_ZERO;
      tos_ff    <= `RCS_PC_ZERO;
      pcv_ff    <= `RCS_PC_ZERO;
      pcld_ff   <= 1'b1;
      crst_ff   <= 1'b1;
    end else begin
      rctl_ff   <= nxt_rctl;
      sfull_ff  <= nxt_sfull;
      sunder_ff <= nxt_sunder;
      sp_ff     <= nxt_sp;
      tos_ff    <= nxt_tos;
      pcv_ff    <= nxt_pcv;
      // wake-ups reload the pc but do not reset the core
      pcld_ff   <= warm_rst | wdog_wk | ev_irq;
      crst_ff   <= warm_rst;
    end
  end

  // pins sit outside this clock; master clear idles released (high)
  always @(posedge ref_clk) begin
    if (rst) begin
      mrst_s1_ff <= 1'b1;
      mrst_s2_ff <= 1'b1;
      mrst_d_ff  <= 1'b1;
      bro_s1_ff  <= 1'b0;
      bro_s2_ff  <= 1'b0;
      bro_d_ff   <= 1'b0;
    end else begin
      mrst_s1_ff <= master_clear_pin_n;
      mrst_s2_ff <= mrst_s1_ff;
      mrst_d_ff  <= mrst_s2_ff;
      bro_s1_ff  <= brownout_pin;
      bro_s2_ff  <= bro_s1_ff;
      bro_d_ff   <= bro_s2_ff;
    end
  end

  // mask, enable and request bits only reset at power-on
  always @(posedge ref_clk) begin
    if (rst) begin
      evt_msk_ff <= {`RCS_EV_N{1'b0}};
      serr_en_ff <= 1'b0;
      ireq_ff    <= 8'h00;
    end else begin
      if (wr_em && w_strb_ff[0]) begin
        evt_msk_ff <= w_data_ff[`RCS_EV_N-1:0];
      end
      if (wr_cf && w_strb_ff[0]) begin
        serr_en_ff <= w_data_ff[`RCS_B_SERR_EN];
      end
      // wake source request bit, set wins over clear
      ireq_ff <= (ireq_ff & ~((wr_iq && w_strb_ff[0]) ? w_data_ff[7:0] :
                 8'h00)) | (ev_irq ? (8'h01 << irq_wake_src) : 8'h00);
    end
  end

  genvar g;
  generate
    for (g = 0; g < `RCS_EV_N; g = g + 1) begin : g_evt
      // sticky, write one to clear, a same-cycle event stays set
      always @(posedge ref_clk) begin
        if (rst) begin
          evt_st_ff[g] <= 1'b0;
        end else if (ev_vec[g]) begin
          evt_st_ff[g] <= 1'b1;
        end else if (wr_es && w_strb_ff[0] && w_data_ff[g]) begin
          evt_st_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // write channel: address and data latched separately, answered together
  always @(posedge ref_clk) begin
    if (rst) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RCS_RESP_OKAY;
      aw_addr_ff <= {`RCS_AW{1'b0}};
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr[`RCS_AW-1:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_hit ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (s_axi_araddr[`RCS_AW-1:0])
      // enable reads zero outside soft mode
      `RCS_A_RST_CTRL: begin
        rd_mux[6:0] = rctl_ff;
        rd_mux[`RCS_B_SWBO_EN] = swbo_en_q & sw_mode;
      end
      `RCS_A_STACK: begin
        rd_mux[`RCS_B_SFULL]  = sfull_ff;
        rd_mux[`RCS_B_SUNDER] = sunder_ff;
        rd_mux[`RCS_SP_W-1:0] = sp_ff;
      end
      `RCS_A_TOS: begin
        rd_mux[`RCS_PC_W-1:0] = tos_ff;
      end
      `RCS_A_IRQ_REQ: begin
        rd_mux[7:0] = ireq_ff;
      end
      `RCS_A_EVT_ST: begin
        rd_mux[`RCS_EV_N-1:0] = evt_st_ff;
      end
      `RCS_A_EVT_MSK: begin
        rd_mux[`RCS_EV_N-1:0] = evt_msk_ff;
      end
      `RCS_A_CFG: begin
        rd_mux[`RCS_B_SERR_EN] = serr_en_ff;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `RCS_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_hit ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready    = ~aw_full_ff & ~bvalid_ff;
  assign s_axi_wready     = ~w_full_ff & ~bvalid_ff;
  assign s_axi_bvalid     = bvalid_ff;
  assign s_axi_bresp      = bresp_ff;
  assign s_axi_arready    = ~rvalid_ff;
  assign s_axi_rvalid     = rvalid_ff;
  assign s_axi_rdata      = rdata_ff;
  assign s_axi_rresp      = rresp_ff;
  assign core_reset       = crst_ff;
  assign pc_load          = pcld_ff;
  assign pc_load_val      = pcv_ff;
  assign irq_request_regs = ireq_ff;
  assign irq              = |(evt_st_ff & evt_msk_ff);

endmodule

// ==== tb/rcs_props.sv ====
// concurrent checks on the reset cause block ports
`timescale 1ns/1ps
`include "rcs_defs.vh"
module rcs_props (
  input wire        ref_clk,
  input wire        rst,
  input wire        master_clear_pin_n,
  input wire        brownout_pin,
  input wire        watchdog_timer_timeout,
  input wire        reset_instr_exec,
  input wire        stack_overflow,
  input wire        stack_underflow,
  input wire        irq_wake,
  input wire [2:0]  irq_wake_src,
  input wire        irq_wake_high_prio,
  input wire        high_prio_global_irq_enable,
  input wire        low_prio_global_irq_enable,
  input wire [1:0]  pm_mode,
  input wire [1:0]  brownout_mode_cfg,
  input wire [20:0] pc_in,
  input wire        core_reset,
  input wire        pc_load,
  input wire [20:0] pc_load_val,
  input wire        brownout_detect_en,
  input wire [7:0]  irq_request_regs
);
  logic [4:0] pins_ok_ff;
  logic       quiet;
  logic       no_wdog;
  logic       solo_irq;
  logic       any_gie;
  // pin events land a few edges late and outrank pulses, so mask that window
  always @(posedge ref_clk) begin
    pins_ok_ff <= {pins_ok_ff[3:0], master_clear_pin_n & ~brownout_pin};
  end
  assign quiet    = &pins_ok_ff;
  assign no_wdog  = quiet & ~watchdog_timer_timeout;
  assign solo_irq = no_wdog & irq_wake & (pm_mode != `RCS_PM_FULL) &
                    ~reset_instr_exec & ~stack_overflow & ~stack_underflow;
  assign any_gie  = high_prio_global_irq_enable | low_prio_global_irq_enable;

  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_por_restart: assert property (
    $fell(rst) |-> core_reset && pc_load && pc_load_val == `RCS_PC_ZERO)
    else $error("no restart at zero after power-on");
  chk_warm_zero: assert property (
    core_reset |-> pc_load && pc_load_val == `RCS_PC_ZERO)
    else $error("warm reset without load of zero");
  chk_wdog_run: assert property (
    quiet && watchdog_timer_timeout && !pm_mode[1]
    |=> core_reset && pc_load && pc_load_val == `RCS_PC_ZERO)
    else $error("watchdog in run did not restart");
  chk_wdog_wake: assert property (
    quiet && watchdog_timer_timeout && pm_mode[1] |=> pc_load &&
    !core_reset && pc_load_val == $past(pc_in) + `RCS_PC_STEP)
    else $error("watchdog wake address wrong");
  chk_rins_restart: assert property (
    no_wdog && reset_instr_exec
    |=> core_reset && pc_load && pc_load_val == `RCS_PC_ZERO)
    else $error("reset instruction did not restart");
  chk_irq_vector: assert property (
    solo_irq && any_gie |=> pc_load && !core_reset && pc_load_val ==
    ($past(irq_wake_high_prio) ? `RCS_VEC_HI : `RCS_VEC_LO))
    else $error("interrupt wake vector wrong");
  chk_irq_step: assert property (
    solo_irq && !any_gie
    |=> pc_load && pc_load_val == $past(pc_in) + `RCS_PC_STEP)
    else $error("interrupt wake address wrong");
  chk_wake_source: assert property (
    solo_irq |=> irq_request_regs[$past(irq_wake_src)])
    else $error("wake source bit not set");
  chk_bro_enable: assert property (
    brownout_mode_cfg != `RCS_BM_SW |-> brownout_detect_en ==
    (brownout_mode_cfg == `RCS_BM_ON || (brownout_mode_cfg == `RCS_BM_NOSLP
    && pm_mode != `RCS_PM_SLEEP)))
    else $error("detector enable wrong for mode");
  chk_pc_hold: assert property (
    !pc_load |-> $stable(pc_load_val))
    else $error("restart address moved without load");
endmodule

bind rcs_reset_cause rcs_props u_props (.ref_clk, .rst, .master_clear_pin_n,
  .brownout_pin, .watchdog_timer_timeout, .reset_instr_exec, .stack_overflow,
  .stack_underflow, .irq_wake, .irq_wake_src, .irq_wake_high_prio,
  .high_prio_global_irq_enable, .low_prio_global_irq_enable, .pm_mode,
  .brownout_mode_cfg, .pc_in, .core_reset, .pc_load, .pc_load_val,
  .brownout_detect_en, .irq_request_regs);

// ==== tb/rcs_src_model.sv ====
// far-side model of the master clear switch and the supply monitor
`timescale 1ns/1ps
module rcs_src_model (
  input  wire  ref_clk,
  output logic master_clear_pin_n,
  output logic brownout_pin
);
  // switch released means the pull-up holds the pin high
  initial begin
    master_clear_pin_n = 1'b1;
    brownout_pin       = 1'b0;
  end
  task automatic press_mrst(input int n);
    @(posedge ref_clk);
    master_clear_pin_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    master_clear_pin_n <= 1'b1;
  endtask
  task automatic dip_supply(input int n);
    @(posedge ref_clk);
    brownout_pin <= 1'b1;
    repeat (n) @(posedge ref_clk);
    brownout_pin <= 1'b0;
  endtask
endmodule

// ==== tb/tb_reset_cause_status_logic.sv ====
// self-checking bench for the reset cause block
`timescale 1ns/1ps
`include "rcs_defs.vh"
module tb_reset_cause_status_logic;
  logic        ref_clk, rst, hi, gie_h, gie_l, mrst_n, bro_pin;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, core_reset, pc_load, bden, irq;
  logic [4:0]  ev;
  logic [2:0]  src;
  logic [1:0]  pm, cfg, bresp, rresp;
  logic [20:0] pc, pcv;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [7:0]  req;
  logic [6:0]  rc;
  int          n_errors, checks;
  localparam logic [22:0] out_rst = 23'h600000;

  rcs_reset_cause u_dut (.ref_clk(ref_clk), .rst(rst),
    .master_clear_pin_n(mrst_n), .brownout_pin(bro_pin),
    .watchdog_timer_timeout(ev[0]), .reset_instr_exec(ev[1]),
    .stack_overflow(ev[2]), .stack_underflow(ev[3]), .irq_wake(ev[4]),
    .irq_wake_src(src), .irq_wake_high_prio(hi),
    .high_prio_global_irq_enable(gie_h), .low_prio_global_irq_enable(gie_l),
    .pm_mode(pm), .brownout_mode_cfg(cfg), .pc_in(pc),
    .core_reset(core_reset), .pc_load(pc_load), .pc_load_val(pcv),
    .brownout_detect_en(bden), .irq_request_regs(req), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rcs_src_model u_src (.ref_clk(ref_clk), .master_clear_pin_n(mrst_n),
    .brownout_pin(bro_pin));

  always #50 ref_clk = ~ref_clk;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    logic       ad, dd, ga, gw, gb;
    logic [1:0] resp;
    ad = 1'b0;
    dd = 1'b0;
    gb = 1'b0;
    resp = 2'h0;
    @(posedge ref_clk);
    awaddr  <= {27'h0, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // answers are looked at mid-cycle, as the coming edge will see them
    while (!(ad && dd)) begin
      @(negedge ref_clk);
      ga = (awready === 1'b1);
      gw = (wready === 1'b1);
      @(posedge ref_clk);
      if (ga && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (gw && !dd) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!gb) begin
      @(negedge ref_clk);
      gb   = (bvalid === 1'b1);
      resp = bresp;
      @(posedge ref_clk);
    end
    bready <= 1'b0;
    cmp({30'h0, resp}, {30'h0, e});
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic        ok;
    logic [31:0] dat;
    logic [1:0]  resp;
    ok = 1'b0;
    dat = 32'h0;
    resp = 2'h0;
    @(posedge ref_clk);
    araddr  <= {27'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!ok) begin
      @(negedge ref_clk);
      ok = (arready === 1'b1);
      @(posedge ref_clk);
    end
    arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge ref_clk);
      ok   = (rvalid === 1'b1);
      dat  = rdata;
      resp = rresp;
      @(posedge ref_clk);
    end
    rready <= 1'b0;
    cmp(dat, e);
    cmp({30'h0, resp}, {30'h0, er});
  endtask
  task automatic fire(input logic [4:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 5'h0;
  endtask
  // first load seen in a fixed window; zero when no pc load is seen
  task automatic poll(output logic [22:0] o);
    o = 23'h0;
    repeat (12) begin
      @(posedge ref_clk);
      #1;
      if (pc_load === 1'b1 && o == 23'h0)
        o = {core_reset, pc_load, pcv};
    end
  endtask
  task automatic ev_case(input int s, input logic [1:0] p,
    input logic [6:0] clr, input logic [6:0] set, input logic [22:0] e);
    logic [22:0] o;
    pm <= p;
    fork
      if (s == 5)
        u_src.press_mrst(2);
      else if (s == 6)
        u_src.dip_supply(4);
      else
        fire(5'h1 << s);
      poll(o);
    join
    cmp({9'h0, o}, {9'h0, e});
    rc = (rc & ~clr) | set;
    rd_chk(`RCS_A_RST_CTRL, {25'h0, rc}, `RCS_RESP_OKAY);
  endtask

  task automatic t_por();
    rd_chk(`RCS_A_RST_CTRL, 32'h5c, `RCS_RESP_OKAY);
    rd_chk(`RCS_A_STACK, 32'h0, `RCS_RESP_OKAY);
    wr(`RCS_A_RST_CTRL, 32'h5e, `RCS_RESP_OKAY);
    rc = 7'h5e;
    rd_chk(`RCS_A_RST_CTRL, 32'h5e, `RCS_RESP_OKAY);
    rd_chk(5'h1c, 32'h0, `RCS_RESP_SLVERR);
    wr(5'h1c, 32'hff, `RCS_RESP_SLVERR);
  endtask
  task automatic t_flags();
    ev_case(0, `RCS_PM_RUN, 7'h08, 7'h00, out_rst);
    ev_case(5, `RCS_PM_RUN, 7'h00, 7'h08, out_rst);
    ev_case(5, `RCS_PM_IDLE, 7'h04, 7'h08, out_rst);
    ev_case(5, `RCS_PM_FULL, 7'h00, 7'h00, out_rst);
    ev_case(1, `RCS_PM_FULL, 7'h10, 7'h00, out_rst);
    wr(`RCS_A_RST_CTRL, 32'h4b, `RCS_RESP_OKAY);
    rc = 7'h4b;
    ev_case(6, `RCS_PM_FULL, 7'h01, 7'h1c, out_rst);
    ev_case(0, `RCS_PM_SLEEP, 7'h0c, 7'h00, {2'b01, pc + 21'h2});
  endtask
  task automatic t_stack();
    ev_case(3, `RCS_PM_FULL, 7'h00, 7'h00, 23'h0);
    rd_chk(`RCS_A_STACK, 32'h40, `RCS_RESP_OKAY);
    ev_case(2, `RCS_PM_FULL, 7'h00, 7'h00, 23'h0);
    wr(`RCS_A_CFG, 32'h1, `RCS_RESP_OKAY);
    ev_case(2, `RCS_PM_FULL, 7'h00, 7'h00, out_rst);
    rd_chk(`RCS_A_STACK, 32'hc0, `RCS_RESP_OKAY);
    ev_case(3, `RCS_PM_FULL, 7'h00, 7'h00, out_rst);
    wr(`RCS_A_STACK, 32'h0, `RCS_RESP_OKAY);
  endtask
  task automatic t_irq();
    src <= 3'h5;
    ev_case(4, `RCS_PM_IDLE, 7'h00, 7'h00, {2'b01, pc + 21'h2});
    rd_chk(`RCS_A_IRQ_REQ, 32'h20, `RCS_RESP_OKAY);
    wr(`RCS_A_IRQ_REQ, 32'h20, `RCS_RESP_OKAY);
    wr(`RCS_A_RST_CTRL, {25'h0, rc | 7'h04}, `RCS_RESP_OKAY);
    rc = rc | 7'h04;
    gie_h <= 1'b1;
    hi    <= 1'b1;
    src   <= 3'h2;
    ev_case(4, `RCS_PM_SLEEP, 7'h04, 7'h00, {2'b01, `RCS_VEC_HI});
    rd_chk(`RCS_A_TOS, {11'h0, pc}, `RCS_RESP_OKAY);
    rd_chk(`RCS_A_STACK, 32'h1, `RCS_RESP_OKAY);
    gie_h <= 1'b0;
    gie_l <= 1'b1;
    hi    <= 1'b0;
    ev_case(4, `RCS_PM_RUN, 7'h00, 7'h00, {2'b01, `RCS_VEC_LO});
    rd_chk(`RCS_A_STACK, 32'h2, `RCS_RESP_OKAY);
    rd_chk(`RCS_A_IRQ_REQ, 32'h04, `RCS_RESP_OKAY);
    ev_case(4, `RCS_PM_FULL, 7'h00, 7'h00, 23'h0);
  endtask
  task automatic t_events();
    rd_chk(`RCS_A_EVT_ST, 32'hff, `RCS_RESP_OKAY);
    cmp({31'h0, irq}, 32'h0);
    wr(`RCS_A_EVT_MSK, 32'h04, `RCS_RESP_OKAY);
    cmp({31'h0, irq}, 32'h1);
    wr(`RCS_A_EVT_ST, 32'h04, `RCS_RESP_OKAY);
    cmp({31'h0, irq}, 32'h0);
    rd_chk(`RCS_A_EVT_ST, 32'hfb, `RCS_RESP_OKAY);
  endtask
  task automatic t_soft_bor();
    cfg <= `RCS_BM_NOSLP;
    rd_chk(`RCS_A_RST_CTRL, {25'h0, rc & 7'h3f}, `RCS_RESP_OKAY);
    cmp({31'h0, bden}, 32'h1);
    fire(5'h02);
    cfg <= `RCS_BM_SW;
    rc = rc & 7'h2f;
    rd_chk(`RCS_A_RST_CTRL, {25'h0, rc}, `RCS_RESP_OKAY);
    cmp({31'h0, bden}, 32'h0);
    ev_case(6, `RCS_PM_FULL, 7'h00, 7'h00, 23'h0);
    for (int i = 0; i < 4; i++) begin
      cfg <= i[1:0];
      @(posedge ref_clk);
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {ev, src, hi, gie_h, gie_l, awvalid, wvalid, bready, arvalid} = '0;
    {rready, awaddr, wdata, araddr, n_errors, checks} = '0;
    pm = `RCS_PM_FULL;
    cfg = `RCS_BM_SW;
    pc = 21'h001234;
    rc = 7'h00;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_por();
    t_flags();
    t_stack();
    t_irq();
    t_events();
    t_soft_bor();
    close_out();
  end
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
endmodule
